// [bpcs_map.svh]
`ifndef BPCS_MAP_SVH
`define BPCS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BPCS_OFF_CMD_STATUS 8'h04
`define BPCS_OFF_IRQ_STATUS 8'h10
`define BPCS_OFF_IRQ_MASK 8'h14

// ----------------------------------------
// Command word bit positions
// ----------------------------------------
`define BPCS_CMD_PAR_RESP 6
`define BPCS_CMD_WAIT_CYCLE 7
`define BPCS_CMD_SERR_EN 8
`define BPCS_CMD_FBB_EN 9
`define BPCS_CMD_INT_DIS 10

// ----------------------------------------
// Primary status bit positions
// ----------------------------------------
`define BPCS_ST_INT_PEND 19
`define BPCS_ST_CAP_LIST 20
`define BPCS_ST_CAP_66 21
`define BPCS_ST_FBB_CAP 23
`define BPCS_ST_MDPE 24

// ----------------------------------------
// Interrupt status bit positions
// ----------------------------------------
`define BPCS_IRQ_PARITY 0
`define BPCS_IRQ_SYSERR 1
`define BPCS_IRQ_INTX 2
`define BPCS_IRQ_COUNT 3

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define BPCS_RST_CAP_LIST 1'h1
`define BPCS_RST_IRQ_MASK 3'h0
`define BPCS_STRAP_SETTLE 2'h2

`endif

// [bpcs_pkg.sv]
package bpcs_pkg;

    // ----------------------------------------
    // Register bus request
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wrData;
        logic write;
        logic read;
    } bpcs_bus_req_t;

    // ----------------------------------------
    // Register bank state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] strapCnt;
        logic strapDone;
        logic reverse;
        logic primaryPci;
        logic parResp;
        logic serrEn;
        logic intDis;
        logic intPending;
        logic sysReqPrev;
        logic [2:0] irqMask;
        logic [31:0] rdData;
        logic serrN;
        logic [3:0] irqN;
        logic errMsg;
        logic irqOut;
        logic serrOe;
        logic [3:0] irqOe;
    } bpcs_state_t;

endpackage : bpcs_pkg

// [bpcs_sync.sv]
module bpcs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } bpcs_sync_t;

    bpcs_sync_t st_r;
    bpcs_sync_t st_nxt;

    // Stage one feeds stage two only; nothing else may look at it
    always_comb begin
        st_nxt = st_r;
        if (clockEnable) begin
            st_nxt.stage1 = asyncIn;
            st_nxt.stage2 = st_r.stage1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign syncOut = st_r.stage2;
endmodule : bpcs_sync

// [bpcs_w1c_bit.sv]
module bpcs_w1c_bit (
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    input wire logic setEvent,
    input wire logic clearStrobe,
    output logic flag
);
    typedef struct packed {
        logic flag;
    } bpcs_w1c_t;

    bpcs_w1c_t st_r;
    bpcs_w1c_t st_nxt;

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        st_nxt = st_r;
        if (clockEnable) begin
            if (setEvent) begin
                st_nxt.flag = 1'b1;
            end else if (clearStrobe) begin
                st_nxt.flag = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flag = st_r.flag;
endmodule : bpcs_w1c_bit

// [bpcs_regs.sv]
// The address-and-strobe port is this design's own decision.
`include "bpcs_map.svh"

module bpcs_regs (
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    input bpcs_pkg::bpcs_bus_req_t busReq,
    output logic [31:0] busRdData,
    input wire logic reverseStrap,
    input wire logic primaryPciStrap,
    input wire logic poisonedTlp,
    input wire logic parityErrorSeen,
    input wire logic [3:0] intxRequest,
    input wire logic systemErrorRequest,
    output logic errorMessageSend,
    output logic system_error_out_n,
    output logic systemErrorOe,
    output logic legacy_irq_a_n,
    output logic legacy_irq_b_n,
    output logic legacy_irq_c_n,
    output logic legacy_irq_d_n,
    output logic [3:0] legacyIrqOe,
    output logic interruptOut
);
    import bpcs_pkg::*;

    // ----------------------------------------
    // State and helpers
    // ----------------------------------------
    bpcs_state_t st_r;
    bpcs_state_t st_nxt;
    logic reverseSync;
    logic pciSync;
    logic mdpeFlag;
    logic mdpeSet;
    logic wrCmd;
    logic wrIrqStat;
    logic [2:0] irqEvent;
    logic [2:0] irqFlag;
    logic serrAssert;
    logic msgStart;
    logic [31:0] cmdStatusWord;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    bpcs_sync #(
        .WIDTH(2)
    ) strapSync (
        .clock(clock),
        .reset(reset),
        .clockEnable(clockEnable),
        .asyncIn({reverseStrap, primaryPciStrap}),
        .syncOut({reverseSync, pciSync})
    );

    // ----------------------------------------
    // Sticky flags
    // ----------------------------------------
    assign wrCmd = busReq.write && (busReq.addr == `BPCS_OFF_CMD_STATUS);
    assign wrIrqStat = busReq.write && (busReq.addr == `BPCS_OFF_IRQ_STATUS);
    assign mdpeSet = st_r.parResp && (poisonedTlp || parityErrorSeen);

    bpcs_w1c_bit mdpeBit (
        .clock(clock),
        .reset(reset),
        .clockEnable(clockEnable),
        .setEvent(mdpeSet),
        .clearStrobe(wrCmd && busReq.wrData[`BPCS_ST_MDPE]),
        .flag(mdpeFlag)
    );

    assign serrAssert = st_r.strapDone && st_r.reverse && st_r.serrEn && systemErrorRequest;
    assign msgStart = st_r.strapDone && !st_r.reverse && st_r.serrEn
        && systemErrorRequest && !st_r.sysReqPrev;

    always_comb begin
        irqEvent = 3'h0;
        irqEvent[`BPCS_IRQ_PARITY] = mdpeSet;
        irqEvent[`BPCS_IRQ_SYSERR] = msgStart || (serrAssert && st_r.serrN);
        irqEvent[`BPCS_IRQ_INTX] = (|intxRequest) && !st_r.intPending;
    end

    for (genvar i = 0; i < `BPCS_IRQ_COUNT; i++) begin : gIrq
        bpcs_w1c_bit irqBit (
            .clock(clock),
            .reset(reset),
            .clockEnable(clockEnable),
            .setEvent(irqEvent[i]),
            .clearStrobe(wrIrqStat && busReq.wrData[i]),
            .flag(irqFlag[i])
        );
    end

    // ----------------------------------------
    // Command and status word
    // ----------------------------------------
    // Unsupported and reserved bits are simply never stored, so writes cannot reach them
    always_comb begin
        cmdStatusWord = 32'h0000_0000;
        cmdStatusWord[`BPCS_CMD_PAR_RESP] = st_r.parResp;
        cmdStatusWord[`BPCS_CMD_SERR_EN] = st_r.serrEn;
        cmdStatusWord[`BPCS_CMD_INT_DIS] = st_r.intDis;
        cmdStatusWord[`BPCS_ST_INT_PEND] = st_r.intPending;
        cmdStatusWord[`BPCS_ST_CAP_LIST] = `BPCS_RST_CAP_LIST;
        cmdStatusWord[`BPCS_ST_CAP_66] = st_r.strapDone && st_r.reverse;
        cmdStatusWord[`BPCS_ST_FBB_CAP] = st_r.strapDone && st_r.reverse && st_r.primaryPci;
        cmdStatusWord[`BPCS_ST_MDPE] = mdpeFlag;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (clockEnable) begin
            // Mode straps are caught once, after the synchroniser has filled
            if (!st_r.strapDone) begin
                if (st_r.strapCnt == `BPCS_STRAP_SETTLE) begin
                    st_nxt.strapDone = 1'b1;
                    st_nxt.reverse = reverseSync;
                    st_nxt.primaryPci = pciSync;
                end else begin
                    st_nxt.strapCnt = st_r.strapCnt + 2'h1;
                end
            end
            if (wrCmd) begin
                st_nxt.parResp = busReq.wrData[`BPCS_CMD_PAR_RESP];
                st_nxt.serrEn = busReq.wrData[`BPCS_CMD_SERR_EN];
                if (st_r.strapDone && st_r.reverse) begin
                    st_nxt.intDis = busReq.wrData[`BPCS_CMD_INT_DIS];
                end
            end
            if (busReq.write && (busReq.addr == `BPCS_OFF_IRQ_MASK)) begin
                st_nxt.irqMask = busReq.wrData[2:0];
            end
            st_nxt.rdData = 32'h0000_0000;
            if (busReq.read) begin
                case (busReq.addr)
                    `BPCS_OFF_CMD_STATUS: st_nxt.rdData = cmdStatusWord;
                    `BPCS_OFF_IRQ_STATUS: st_nxt.rdData = {29'h0000_0000, irqFlag};
                    `BPCS_OFF_IRQ_MASK: st_nxt.rdData = {29'h0000_0000, st_r.irqMask};
                    default: st_nxt.rdData = 32'h0000_0000;
                endcase
            end
            st_nxt.intPending = |intxRequest;
            st_nxt.sysReqPrev = systemErrorRequest;
            st_nxt.serrN = !serrAssert;
            st_nxt.serrOe = serrAssert;
            st_nxt.errMsg = msgStart;
            // Legacy pins only exist in reverse mode, whatever the primary strap
            st_nxt.irqOe = intxRequest & {4{st_r.strapDone && st_r.reverse && !st_r.intDis}};
            // Enables get flops of their own so no pin ever switches through a gate
            st_nxt.irqN = ~st_nxt.irqOe;
            st_nxt.irqOut = |(irqFlag & st_r.irqMask);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '{serrN: 1'b1, irqN: 4'hF, irqMask: `BPCS_RST_IRQ_MASK, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign busRdData = st_r.rdData;
    assign errorMessageSend = st_r.errMsg;
    assign system_error_out_n = st_r.serrN;
    assign systemErrorOe = st_r.serrOe;
    assign legacy_irq_a_n = st_r.irqN[0];
    assign legacy_irq_b_n = st_r.irqN[1];
    assign legacy_irq_c_n = st_r.irqN[2];
    assign legacy_irq_d_n = st_r.irqN[3];
    assign legacyIrqOe = st_r.irqOe;
    assign interruptOut = st_r.irqOut;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    logic readCmd;
    assign readCmd = clockEnable && busReq.read && (busReq.addr == `BPCS_OFF_CMD_STATUS);

    a_parity_flag_set: assert property (
        (clockEnable && st_r.parResp && (poisonedTlp || parityErrorSeen)) |=> mdpeFlag
    ) else $error("parity flag not set while response enabled");

    a_wait_bit_zero: assert property (
        readCmd |=> (busRdData[`BPCS_CMD_WAIT_CYCLE] == 1'b0)
    ) else $error("wait cycle bit read nonzero");

    a_error_message_gate: assert property (
        errorMessageSend |-> ($past(st_r.serrEn) && !st_r.reverse && !$past(errorMessageSend))
    ) else $error("error message sent without enable");

    a_serr_pin_gate: assert property (
        !system_error_out_n |-> ($past(st_r.serrEn) && st_r.reverse && $past(systemErrorRequest))
    ) else $error("system error pin asserted while disabled");

    a_fbb_enable_zero: assert property (
        readCmd |=> (busRdData[`BPCS_CMD_FBB_EN] == 1'b0)
    ) else $error("fast back-to-back enable read nonzero");

    a_intx_disabled: assert property (
        (clockEnable && st_r.intDis) |=> (legacyIrqOe == 4'h0) && (legacy_irq_a_n && legacy_irq_d_n)
    ) else $error("legacy interrupt driven while disabled");

    a_intdis_forward_ro: assert property (
        (st_r.strapDone && !st_r.reverse && wrCmd) |=> (st_r.intDis == 1'b0)
    ) else $error("interrupt disable changed in forward mode");

    a_pending_status: assert property (
        readCmd |=> (busRdData[`BPCS_ST_INT_PEND] == $past(st_r.intPending))
    ) else $error("interrupt pending status wrong");

    a_cap_list_one: assert property (
        readCmd |=> busRdData[`BPCS_ST_CAP_LIST]
    ) else $error("capability list bit not one");

    a_cap66_mode: assert property (
        (readCmd && st_r.strapDone) |=> (busRdData[`BPCS_ST_CAP_66] == st_r.reverse)
    ) else $error("66 MHz capable bit mismatches mode");

    a_fbb_cap_mode: assert property (
        (readCmd && st_r.strapDone) |=> (busRdData[`BPCS_ST_FBB_CAP] == (st_r.reverse && st_r.primaryPci))
    ) else $error("fast back-to-back capable bit wrong");

    a_reserved_zero: assert property (
        readCmd |=> ((busRdData[15:11] == 5'h00) && (busRdData[18:16] == 3'h0) && !busRdData[22])
    ) else $error("reserved bit read nonzero");

    a_mdpe_needs_enable: assert property (
        (!mdpeFlag ##1 mdpeFlag) |-> $past(st_r.parResp)
    ) else $error("parity flag set with response disabled");

    // The master may leave a gap after a write, so the read back may come one or two cycles later
    a_ro_write_ignored: assert property (
        (clockEnable && wrCmd && busReq.wrData[`BPCS_CMD_WAIT_CYCLE] && busReq.read == 1'b0) ##[1:2] readCmd
        |=> !busRdData[`BPCS_CMD_WAIT_CYCLE] && !busRdData[`BPCS_CMD_FBB_EN]
    ) else $error("read-only bit took a written value");

    a_parity_write_rw: assert property (
        (clockEnable && wrCmd) |=> (st_r.parResp == $past(busReq.wrData[`BPCS_CMD_PAR_RESP]))
    ) else $error("parity response enable did not take written value");

    a_serr_en_write: assert property (
        (clockEnable && wrCmd) |=> (st_r.serrEn == $past(busReq.wrData[`BPCS_CMD_SERR_EN]))
    ) else $error("system error enable did not take written value");

    a_message_pulse: assert property (
        (clockEnable && msgStart) |=> errorMessageSend
    ) else $error("error message not sent on enabled request");

    a_message_needs_enable: assert property (
        (clockEnable && !st_r.serrEn) |=> !errorMessageSend
    ) else $error("error message sent while enable clear");

    a_message_reverse_idle: assert property (
        (st_r.strapDone && st_r.reverse) |-> !errorMessageSend
    ) else $error("error message sent in reverse mode");

    a_serr_follow: assert property (
        (clockEnable && st_r.strapDone && st_r.reverse && st_r.serrEn)
        |=> (system_error_out_n == !$past(systemErrorRequest))
    ) else $error("system error pin does not follow request");

    a_serr_released: assert property (
        (clockEnable && !st_r.serrEn) |=> system_error_out_n
    ) else $error("system error pin low while enable clear");

    a_serr_forward_idle: assert property (
        (st_r.strapDone && !st_r.reverse) |-> system_error_out_n
    ) else $error("system error pin low in forward mode");

    a_serr_oe_match: assert property (
        systemErrorOe == !system_error_out_n
    ) else $error("system error enable disagrees with pin level");

    a_intx_oe_match: assert property (
        legacyIrqOe == ~{legacy_irq_d_n, legacy_irq_c_n, legacy_irq_b_n, legacy_irq_a_n}
    ) else $error("legacy interrupt enable disagrees with pin level");

    a_intx_follow: assert property (
        (clockEnable && st_r.strapDone && st_r.reverse && !st_r.intDis) |=> (legacyIrqOe == $past(intxRequest))
    ) else $error("legacy interrupt pins do not follow requests");

    a_intdis_reads_back: assert property (
        readCmd |=> (busRdData[`BPCS_CMD_INT_DIS] == $past(st_r.intDis))
    ) else $error("interrupt disable read back wrong");

    a_intdis_reverse_rw: assert property (
        (clockEnable && wrCmd && st_r.strapDone && st_r.reverse)
        |=> (st_r.intDis == $past(busReq.wrData[`BPCS_CMD_INT_DIS]))
    ) else $error("interrupt disable not writable in reverse mode");

    a_intdis_unstrapped_ro: assert property (
        !st_r.strapDone |=> !st_r.intDis
    ) else $error("interrupt disable set before mode known");

    a_pending_follow: assert property (
        clockEnable |=> (st_r.intPending == $past(|intxRequest))
    ) else $error("interrupt pending does not follow requests");

    a_cap_unstrapped: assert property (
        (readCmd && !st_r.strapDone) |=> !busRdData[`BPCS_ST_CAP_66] && !busRdData[`BPCS_ST_FBB_CAP]
    ) else $error("mode capability bit set before mode known");

    a_mdpe_in_word: assert property (
        readCmd |=> (busRdData[`BPCS_ST_MDPE] == $past(mdpeFlag))
    ) else $error("parity flag read back wrong");

    a_mdpe_w1c: assert property (
        (clockEnable && wrCmd && busReq.wrData[`BPCS_ST_MDPE] && !mdpeSet) |=> !mdpeFlag
    ) else $error("parity flag not cleared by writing one");

    a_mdpe_sticky: assert property (
        (clockEnable && mdpeFlag && !(wrCmd && busReq.wrData[`BPCS_ST_MDPE])) |=> mdpeFlag
    ) else $error("parity flag dropped without clear");

    c_parity_flag: cover property (mdpeSet ##1 mdpeFlag);
    c_serr_pin: cover property (!system_error_out_n);
    c_message_sent: cover property (errorMessageSend);
    c_irq_raised: cover property (interruptOut);
    c_parity_cleared: cover property (mdpeFlag ##1 !mdpeFlag);
endmodule : bpcs_regs

// [bpcs_host_model.sv]
module bpcs_host_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic system_error_out_n,
    input wire logic systemErrorOe,
    input wire logic [3:0] legacyIrqN,
    input wire logic [3:0] legacyIrqOe,
    input wire logic errorMessageSend,
    output logic serrWire,
    output logic [3:0] intWire,
    output logic [7:0] msgCount
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Open-drain lines with pull-ups
    // ----------------------------------------
    // A released line reads high, never the last driven level
    assign serrWire = systemErrorOe ? system_error_out_n : 1'b1;
    assign intWire = (legacyIrqOe & legacyIrqN) | ~legacyIrqOe;

    // ----------------------------------------
    // Error message counting
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            msgCount <= 8'h00;
        end else if (errorMessageSend) begin
            msgCount <= msgCount + 8'h01;
        end
    end
endmodule : bpcs_host_model

// [test_bpcs_regs.sv]
module test_bpcs_regs;
    import bpcs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clockEnable = 1'b1;
    bpcs_bus_req_t busReq = '0;
    logic [31:0] busRdData;
    logic reverseStrap = 1'b0;
    logic primaryPciStrap = 1'b0;
    logic poisonedTlp = 1'b0;
    logic parityErrorSeen = 1'b0;
    logic [3:0] intxRequest = 4'h0;
    logic systemErrorRequest = 1'b0;
    logic errorMessageSend, serrN, serrOe, interruptOut, serrWire;
    logic [3:0] irqN, irqOe, intWire;
    logic [7:0] msgCount;
    logic [31:0] rdVal;
    logic rev, pci;
    int errors = 0;
    int check_count = 0;

    always #5 clock = ~clock;

    bpcs_regs uut (
        .clock(clock), .reset(reset), .clockEnable(clockEnable), .busReq(busReq), .busRdData(busRdData),
        .reverseStrap(reverseStrap), .primaryPciStrap(primaryPciStrap), .poisonedTlp(poisonedTlp),
        .parityErrorSeen(parityErrorSeen), .intxRequest(intxRequest), .systemErrorRequest(systemErrorRequest),
        .errorMessageSend(errorMessageSend), .system_error_out_n(serrN), .systemErrorOe(serrOe),
        .legacy_irq_a_n(irqN[0]), .legacy_irq_b_n(irqN[1]), .legacy_irq_c_n(irqN[2]),
        .legacy_irq_d_n(irqN[3]), .legacyIrqOe(irqOe), .interruptOut(interruptOut)
    );

    bpcs_host_model host (
        .clock(clock), .reset(reset), .system_error_out_n(serrN), .systemErrorOe(serrOe),
        .legacyIrqN(irqN), .legacyIrqOe(irqOe), .errorMessageSend(errorMessageSend),
        .serrWire(serrWire), .intWire(intWire), .msgCount(msgCount)
    );

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        busReq <= '{addr: a, wrData: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        busReq.write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        busReq <= '{addr: a, wrData: 32'h0, write: 1'b0, read: 1'b1};
        @(posedge clock);
        busReq.read <= 1'b0;
        @(posedge clock);
        rdVal = busRdData;
    endtask : rd

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic pulse(input int which);
        @(posedge clock);
        if (which == 0) parityErrorSeen <= 1'b1;
        else poisonedTlp <= 1'b1;
        @(posedge clock);
        parityErrorSeen <= 1'b0;
        poisonedTlp <= 1'b0;
    endtask : pulse

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------
    // One pass for each of three strap settings
    // ----------------------------------------
    // Straps are caught once after reset, so each mode needs its own reset
    initial begin
        for (int m = 0; m < 3; m++) begin
            rev = (m != 0);
            pci = (m != 2);
            @(posedge clock);
            reset <= 1'b1;
            reverseStrap <= rev;
            primaryPciStrap <= pci;
            repeat (6) @(posedge clock);
            reset <= 1'b0;
            repeat (8) @(posedge clock);
            rd(8'h04);
            chk("word04 reset", {8'h00, rev & pci, 1'b0, rev, 1'b1, 4'h0, 16'h0000}, rdVal);
            wr(8'h04, 32'hFFFF_FFFF);
            rd(8'h04);
            chk("word04 ones", {8'h00, rev & pci, 1'b0, rev, 5'h10, 5'h00, rev, 10'h140}, rdVal);
            intxRequest <= 4'h5;
            repeat (3) @(posedge clock);
            chk("intx disabled", rev ? 32'hF : 32'hF, {28'h0, intWire});
            rd(8'h04);
            chk("intx pending", 32'h1, {31'h0, rdVal[19]});
            wr(8'h04, 32'h0000_0140);
            repeat (3) @(posedge clock);
            chk("intx enabled", rev ? 32'hA : 32'hF, {28'h0, intWire});
            intxRequest <= 4'h0;
            repeat (3) @(posedge clock);
            rd(8'h04);
            chk("intx idle", 32'h0, {31'h0, rdVal[19]});
            wr(8'h14, 32'h0);
            wr(8'h10, 32'h7);
            pulse(0);
            rd(8'h04);
            chk("parity flag", 32'h1, {31'h0, rdVal[24]});
            chk("irq masked", 32'h0, {31'h0, interruptOut});
            wr(8'h14, 32'h7);
            repeat (2) @(posedge clock);
            chk("irq unmasked", 32'h1, {31'h0, interruptOut});
            wr(8'h04, 32'h0100_0140);
            wr(8'h10, 32'h7);
            rd(8'h04);
            chk("parity clear", 32'h0, {31'h0, rdVal[24]});
            chk("irq cleared", 32'h0, {31'h0, interruptOut});
            clockEnable <= 1'b0;
            wr(8'h14, 32'h0000_0005);
            clockEnable <= 1'b1;
            rd(8'h14);
            chk("frozen mask", 32'h7, rdVal);
            wr(8'h04, 32'h0000_0100);
            pulse(1);
            rd(8'h04);
            chk("parity ignored", 32'h0, {31'h0, rdVal[24]});
            systemErrorRequest <= 1'b1;
            repeat (3) @(posedge clock);
            chk("serr pin", rev ? 32'h0 : 32'h1, {31'h0, serrWire});
            chk("err message", rev ? 32'h0 : 32'h1, {24'h0, msgCount});
            systemErrorRequest <= 1'b0;
            rd(8'h10);
            chk("irq syserr", 32'h1, {31'h0, rdVal[1]});
            wr(8'h04, 32'h0);
            systemErrorRequest <= 1'b1;
            repeat (3) @(posedge clock);
            chk("serr off", 32'h1, {31'h0, serrWire});
            chk("message off", rev ? 32'h0 : 32'h1, {24'h0, msgCount});
            systemErrorRequest <= 1'b0;
            rd(8'h20);
            chk("unmapped", 32'h0, rdVal);
            $display("test mode %0d done", m);
        end
        summarize();
    end
endmodule : test_bpcs_regs
